// [uefm_pkg.sv]
// shared constants and carriers for the endpoint flag output mask block
// assumes a classic wishbone master with 32-bit data and byte selects
package uefm_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int unsigned NUM_EP  = 8;
	localparam int unsigned ADR_W   = 8;
	localparam int unsigned DAT_W   = 32;
	localparam int unsigned SEL_W   = 4;
	localparam int unsigned MAIN_W  = 2;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_MASK      = 8'h00;
	localparam logic [7:0] OFS_DONE      = 8'h04;
	localparam logic [7:0] OFS_RX0       = 8'h08;
	localparam logic [7:0] OFS_MAIN      = 8'h0c;
	localparam logic [7:0] OFS_MAIN_MASK = 8'h10;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int unsigned MAIN_EP_BIT   = 0;
	localparam int unsigned MAIN_RX0_BIT  = 1;
	localparam logic [7:0]  EP_MASK_RST   = 8'h00;
	localparam logic [7:0]  RSVD_MASK_RST = 8'h00;
	localparam logic [1:0]  MAIN_MASK_RST = 2'h0;
	// endpoint 0 has no done path to the endpoint interrupt
	localparam logic [7:0]  DONE_VALID    = 8'hfe;
	localparam logic [7:0]  RX0_VALID     = 8'hff;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [SEL_W-1:0] sel;
		logic [ADR_W-1:0] adr;
		logic [DAT_W-1:0] dat;
	} uefm_wb_req_t;

	typedef struct packed {
		logic ep;
		logic rx0;
		logic main;
	} uefm_irq_t;

endpackage : uefm_pkg

// [uefm_sticky_bank.sv]
// sticky flag bank, set by hardware events, cleared by write-one
// assumes set and clear pulses come from logic on the same clock
`timescale 1ns/10ps
module uefm_sticky_bank #(
	parameter int unsigned W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output logic      [W-1:0] flags_o
);
	import uefm_pkg::*;

	logic [W-1:0] flags_reg;
	logic [W-1:0] flags_next;

	// set wins over a clear in the same cycle
	always_comb begin
		flags_next = (flags_reg & ~clr_i) | set_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags_o = flags_reg;

	set_wins_a : assert property (@(posedge clk_i) disable iff (rst_i)
		(set_i != '0) |=> ((flags_reg & $past(set_i)) == $past(set_i)))
		else $error("event lost against clear");

endmodule : uefm_sticky_bank

// [uefm_mask_gate.sv]
// gates a flag vector by a mask onto one level
// assumes mask bit one suppresses, valid selects bits that count
`timescale 1ns/10ps
module uefm_mask_gate #(
	parameter int unsigned W = 8
) (
	input  wire logic [W-1:0] flags_i,
	input  wire logic [W-1:0] mask_i,
	input  wire logic [W-1:0] valid_i,
	output logic              level_o
);
	import uefm_pkg::*;

	assign level_o = |(flags_i & ~mask_i & valid_i);

endmodule : uefm_mask_gate

// [uefm_flag_mask.sv]
// endpoint flag output mask with wishbone register port
// assumes done and zero-length pulses come from same-clock engines
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps

// What this block does
// R01: eight mask bits 7..0; zero passes endpoint flag to outputs, one suppresses.
// R02: masked endpoint still sets done flag but never drives endpoint interrupt.
// R03: masked endpoint still sets zero-length flag but never drives zero-length interrupt.
// R04: mask bit 0 only affects zero-length path, not the done interrupt.
// R05: software masks every dma-serviced endpoint after initialisation.
// R06: multi-endpoint software uses per-endpoint flags, keeps summary mask zero.
// R07: summary endpoint flag is the single endpoint source, cleared there, gated by mask.
// R08: single-endpoint software masks dma endpoints, unmasks the register-port endpoint.
// R09: software reprograms master transfers after resume before restarting them.
// R10: software writes zero to bits 15..8; bits 31..16 read undefined.
// R11: interrupt outputs high while any unmasked flag of their kind is set, except the endpoint 0 done flag, which never drives one.
module uefm_flag_mask #(
	parameter int unsigned EP_N = uefm_pkg::NUM_EP
) (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire uefm_pkg::uefm_wb_req_t      wb_req_i,
	output logic      [uefm_pkg::DAT_W-1:0]  wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic [EP_N-1:0]             ep_done_i,
	input  wire logic [EP_N-1:0]             rx_zero_i,
	output logic                             ep_irq_o,
	output logic                             zero_len_irq_o,
	output logic                             irq_o
);
	import uefm_pkg::*;

	// ****************************************
	// state
	// ****************************************
	logic [EP_N-1:0]   ep_mask_reg;
	logic [7:0]        rsvd_mask_reg;
	logic [MAIN_W-1:0] main_mask_reg;
	logic              ack_reg;
	logic [DAT_W-1:0]  rdat_reg;
	logic [DAT_W-1:0]  rdat_next;

	logic [EP_N-1:0]   done_flags;
	logic [EP_N-1:0]   rx0_flags;
	logic [MAIN_W-1:0] main_flags;
	logic [EP_N-1:0]   done_clr;
	logic [EP_N-1:0]   rx0_clr;
	logic [MAIN_W-1:0] main_clr;
	logic [MAIN_W-1:0] main_set;
	logic              req;
	logic              wr_commit;
	logic              mask_wr;
	logic [7:0]        main_w1c;
	logic              ep_lvl;
	logic              rx0_lvl;
	logic              main_lvl;
	uefm_irq_t         irq;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
		hit = (adr == ofs);
	endfunction : hit

	function automatic logic [7:0] w1c_byte(input uefm_wb_req_t r, input logic [7:0] ofs);
		w1c_byte = (hit(r.adr, ofs) && r.sel[0]) ? r.dat[7:0] : 8'h00;
	endfunction : w1c_byte

	// ****************************************
	// wishbone handshake
	// ****************************************
	assign req = wb_req_i.cyc & wb_req_i.stb;
	// commit on the edge at which the master sees ack high
	assign wr_commit = req & wb_req_i.we & ack_reg;
	assign mask_wr   = wr_commit & hit(wb_req_i.adr, OFS_MASK);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	assign wb_ack_o = ack_reg;

	// ****************************************
	// read data
	// ****************************************
	always_comb begin
		rdat_next = '0;
		case (wb_req_i.adr)
			OFS_MASK: begin
				// upper half reads zero as a safe choice
				rdat_next[15:0] = {rsvd_mask_reg, ep_mask_reg};
			end
			OFS_DONE: begin
				rdat_next[7:0] = done_flags;
			end
			OFS_RX0: begin
				rdat_next[7:0] = rx0_flags;
			end
			OFS_MAIN: begin
				rdat_next[MAIN_W-1:0] = main_flags;
			end
			OFS_MAIN_MASK: begin
				rdat_next[MAIN_W-1:0] = main_mask_reg;
			end
			default: begin
				rdat_next = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_reg <= '0;
		end else if (req & ~ack_reg & ~wb_req_i.we) begin
			rdat_reg <= rdat_next;
		end
	end

	assign wb_dat_o = rdat_reg;

	// ****************************************
	// mask registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ep_mask_reg   <= EP_MASK_RST;
			rsvd_mask_reg <= RSVD_MASK_RST;
		end else if (wr_commit && hit(wb_req_i.adr, OFS_MASK)) begin
			if (wb_req_i.sel[0]) begin
				ep_mask_reg <= wb_req_i.dat[7:0]; // R01
			end
			if (wb_req_i.sel[1]) begin
				// stored but steers nothing; software should keep it zero
				rsvd_mask_reg <= wb_req_i.dat[15:8]; // R10
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_mask_reg <= MAIN_MASK_RST;
		end else if (wr_commit && hit(wb_req_i.adr, OFS_MAIN_MASK) && wb_req_i.sel[0]) begin
			main_mask_reg <= wb_req_i.dat[MAIN_W-1:0]; // R07
		end
	end

	// ****************************************
	// sticky flags
	// ****************************************
	always_comb begin
		main_w1c = wr_commit ? w1c_byte(wb_req_i, OFS_MAIN) : 8'h00;
		done_clr = wr_commit ? w1c_byte(wb_req_i, OFS_DONE) : 8'h00;
		rx0_clr  = wr_commit ? w1c_byte(wb_req_i, OFS_RX0) : 8'h00;
		main_clr = main_w1c[MAIN_W-1:0];
	end

	// flags record regardless of mask
	uefm_sticky_bank #(
		.W (EP_N)
	) u_done (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (ep_done_i), // R02
		.clr_i   (done_clr),
		.flags_o (done_flags)
	);

	uefm_sticky_bank #(
		.W (EP_N)
	) u_rx0 (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (rx_zero_i), // R03
		.clr_i   (rx0_clr),
		.flags_o (rx0_flags)
	);

	// summary source follows only unmasked endpoints
	always_comb begin
		main_set = '0;
		main_set[MAIN_EP_BIT]  = |(ep_done_i & ~ep_mask_reg & DONE_VALID); // R07
		main_set[MAIN_RX0_BIT] = |(rx_zero_i & ~ep_mask_reg & RX0_VALID);
	end

	uefm_sticky_bank #(
		.W (MAIN_W)
	) u_main (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (main_set),
		.clr_i   (main_clr),
		.flags_o (main_flags)
	);

	// ****************************************
	// output gating
	// ****************************************
	uefm_mask_gate #(
		.W (EP_N)
	) u_ep_gate (
		.flags_i (done_flags),
		.mask_i  (ep_mask_reg),
		.valid_i (DONE_VALID), // R04
		.level_o (ep_lvl) // R11
	);

	uefm_mask_gate #(
		.W (EP_N)
	) u_rx0_gate (
		.flags_i (rx0_flags),
		.mask_i  (ep_mask_reg),
		.valid_i (RX0_VALID),
		.level_o (rx0_lvl) // R11
	);

	uefm_mask_gate #(
		.W (MAIN_W)
	) u_main_gate (
		.flags_i (main_flags),
		.mask_i  (main_mask_reg),
		.valid_i ({MAIN_W{1'b1}}),
		.level_o (main_lvl) // R07
	);

	// one driver for the whole carrier rather than one per member
	assign irq = '{ep: ep_lvl, rx0: rx0_lvl, main: main_lvl};
	assign ep_irq_o       = irq.ep;
	assign zero_len_irq_o = irq.rx0;
	assign irq_o          = irq.main;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_req_held;
		req & ~ack_reg;
	endsequence

	sequence s_ack_once;
		ack_reg ##1 !ack_reg;
	endsequence

	sequence s_done_w1c;
		wr_commit && hit(wb_req_i.adr, OFS_DONE) && wb_req_i.sel[0];
	endsequence

	ack_one_cycle_a : assert property (s_req_held |=> s_ack_once)
		else $error("ack not a single pulse");

	mask_write_a : assert property (mask_wr && wb_req_i.sel[0] // R01
		|=> ep_mask_reg == $past(wb_req_i.dat[7:0]))
		else $error("mask write not stored");

	done_records_a : assert property ((ep_done_i & ep_mask_reg) != 8'h00 // R02
		|=> (done_flags & $past(ep_done_i)) == $past(ep_done_i))
		else $error("masked done event not recorded");

	done_clear_a : assert property (s_done_w1c // R02
		|=> (done_flags & $past(wb_req_i.dat[7:0]) & ~$past(ep_done_i)) == 8'h00)
		else $error("done flag not cleared");

	rx0_records_a : assert property ((rx_zero_i & ep_mask_reg) != 8'h00 // R03
		|=> (rx0_flags & $past(rx_zero_i)) == $past(rx_zero_i))
		else $error("masked zero-length event not recorded");

	masked_ep_quiet_a : assert property ((done_flags & ~ep_mask_reg & DONE_VALID) == 8'h00 // R02
		|-> !ep_irq_o)
		else $error("endpoint interrupt from masked flag");

	masked_rx0_quiet_a : assert property ((rx0_flags & ~ep_mask_reg) == 8'h00 // R03
		|-> !zero_len_irq_o)
		else $error("zero-length interrupt from masked flag");

	bit0_rx_only_a : assert property ((done_flags == 8'h01) |-> !ep_irq_o) // R04
		else $error("endpoint 0 reached endpoint interrupt");

	ep0_no_summary_a : assert property (ep_done_i == 8'h01 && !main_flags[MAIN_EP_BIT] // R04
		|=> !main_flags[MAIN_EP_BIT])
		else $error("endpoint 0 set the summary flag");

	// a mask write landing with the event may legally hide it
	unmasked_done_irq_a : assert property ((ep_done_i & ~ep_mask_reg & DONE_VALID) != 8'h00 && !mask_wr // R11
		|=> ep_irq_o && main_flags[MAIN_EP_BIT])
		else $error("unmasked done did not raise interrupt");

	unmasked_rx0_irq_a : assert property ((rx_zero_i & ~ep_mask_reg) != 8'h00 && !mask_wr // R11
		|=> zero_len_irq_o)
		else $error("unmasked zero-length did not raise interrupt");

	summary_rx0_set_a : assert property ((rx_zero_i & ~ep_mask_reg) != 8'h00 // R07
		|=> main_flags[MAIN_RX0_BIT])
		else $error("summary zero-length flag not set");

	summary_gate_a : assert property (irq_o == |(main_flags & ~main_mask_reg)) // R07
		else $error("summary interrupt gating wrong");

	summary_clear_a : assert property (wr_commit && hit(wb_req_i.adr, OFS_MAIN) // R07
		&& wb_req_i.sel[0] && wb_req_i.dat[MAIN_EP_BIT] && !main_set[MAIN_EP_BIT]
		|=> !main_flags[MAIN_EP_BIT])
		else $error("summary flag not cleared");

endmodule : uefm_flag_mask

// [uefm_ev_model.sv]
// event source standing in for the transfer engines and the dma side
// assumes one bus clock; every event is a one-cycle pulse on that clock
`timescale 1ns/10ps
module uefm_ev_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	output logic      [7:0] ep_done_o,
	output logic      [7:0] rx_zero_o
);
	// ****************************************
	// pulse source
	// ****************************************
	initial begin
		ep_done_o = '0;
		rx_zero_o = '0;
	end
	// engines never hold a level, so drop the pulse after one edge
	task automatic pulse(input logic [7:0] d, input logic [7:0] z);
		@(posedge clk_i);
		ep_done_o <= rst_i ? 8'h00 : d;
		rx_zero_o <= rst_i ? 8'h00 : z;
		@(posedge clk_i);
		ep_done_o <= '0;
		rx_zero_o <= '0;
	endtask : pulse
endmodule : uefm_ev_model

// [usb_endpoint_flag_output_mask_tb.sv]
// self-checking bench for the endpoint flag output mask block
// assumes the event source model and a 25 MHz bus clock
`timescale 1ns/10ps
module usb_endpoint_flag_output_mask_tb;
	import uefm_pkg::*;
	// ****************************************
	// signals and reference state
	// ****************************************
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	uefm_wb_req_t req   = '0;
	logic [31:0]  wb_dat_o;
	logic         wb_ack_o;
	logic [7:0]   ep_done;
	logic [7:0]   rx_zero;
	logic         ep_irq_o;
	logic         zero_len_irq_o;
	logic         irq_o;
	int           error_cnt  = 0;
	int           num_checks = 0;
	logic [31:0]  seed = 32'hd6b3da8b;
	logic [31:0]  r;
	logic [31:0]  rdat;
	logic [7:0]   d;
	logic [7:0]   z;
	logic [7:0]   m_mask = '0;
	logic [7:0]   m_done = '0;
	logic [7:0]   m_rx0  = '0;
	logic [1:0]   m_main = '0;
	logic [1:0]   m_mmsk = '0;

	always #20 clk_i = ~clk_i;

	uefm_flag_mask dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ep_done_i(ep_done), .rx_zero_i(rx_zero), .ep_irq_o(ep_irq_o),
		.zero_len_irq_o(zero_len_irq_o), .irq_o(irq_o));
	uefm_ev_model ev (.clk_i(clk_i), .rst_i(rst_i), .ep_done_o(ep_done), .rx_zero_o(rx_zero));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		for (int k = 0; k < 8; k++) begin
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		end
		return seed;
	endfunction : rnd

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// classic cycle: hold until ack is sampled, release at that edge
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n = 0;
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chk("ack", 32'h1, {31'h0, wb_ack_o});
		rdat = wb_dat_o;
		req  <= '0;
	endtask : bus

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		bus(1'b1, adr, dat);
		case (adr)
			OFS_MASK:      m_mask = dat[7:0];
			OFS_DONE:      m_done &= ~dat[7:0];
			OFS_RX0:       m_rx0 &= ~dat[7:0];
			OFS_MAIN:      m_main &= ~dat[1:0];
			OFS_MAIN_MASK: m_mmsk = dat[1:0];
			default:       ;
		endcase
	endtask : wr

	task automatic rd(input logic [7:0] adr);
		logic [31:0] e;
		bus(1'b0, adr, 32'h0);
		case (adr)
			OFS_MASK:      e = {24'h0, m_mask};
			OFS_DONE:      e = {24'h0, m_done};
			OFS_RX0:       e = {24'h0, m_rx0};
			OFS_MAIN:      e = {30'h0, m_main};
			OFS_MAIN_MASK: e = {30'h0, m_mmsk};
			default:       e = 32'h0;
		endcase
		chk($sformatf("read %h", adr), e, rdat);
	endtask : rd

	task automatic chk_irq();
		#1;
		chk("ep_irq_o", {31'h0, |(m_done & ~m_mask & DONE_VALID)}, {31'h0, ep_irq_o});
		chk("zero_len_irq_o", {31'h0, |(m_rx0 & ~m_mask)}, {31'h0, zero_len_irq_o});
		chk("irq_o", {31'h0, |(m_main & ~m_mmsk)}, {31'h0, irq_o});
	endtask : chk_irq

	// one engine pulse, folded into the reference state
	task automatic ev_step(input logic [7:0] dv, input logic [7:0] zv);
		ev.pulse(dv, zv);
		m_done |= dv;
		m_rx0 |= zv;
		m_main[0] |= |(dv & ~m_mask & DONE_VALID);
		m_main[1] |= |(zv & ~m_mask);
	endtask : ev_step

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// ****************************************
	// tests
	// ****************************************
	initial begin
		#800000;
		error_cnt++;
		conclude();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 6; a++) rd(8'(a * 4));
		chk_irq();
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			// first pass masks all endpoints, second opens all, later passes use random masks
			wr(OFS_MASK, {24'h0, i == 0 ? 8'hff : i == 1 ? 8'h00 : r[7:0]});
			wr(OFS_MAIN_MASK, {30'h0, i < 2 ? 2'h0 : r[9:8]});
			rd(OFS_MASK);
			d = i == 0 ? 8'hff : i == 1 ? 8'h01 : r[23:16];
			z = i == 0 ? 8'hff : i == 1 ? 8'h01 : r[31:24];
			ev_step(d, z);
			chk_irq();
			rd(OFS_DONE);
			rd(OFS_RX0);
			rd(OFS_MAIN);
			r = rnd();
			wr(OFS_DONE, {24'h0, r[7:0]});
			wr(OFS_RX0, {24'h0, r[15:8]});
			wr(OFS_MAIN, {30'h0, r[17:16]});
			chk_irq();
		end
		$display("test events done");
		// mid-run reset, then software sets the masks up again before events resume
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		m_mask = '0;
		m_done = '0;
		m_rx0  = '0;
		m_main = '0;
		m_mmsk = '0;
		for (int a = 0; a < 6; a++) rd(8'(a * 4));
		chk_irq();
		wr(OFS_MASK, {24'h0, 8'h06});
		wr(OFS_MAIN_MASK, {30'h0, 2'h2});
		ev_step(8'h0f, 8'h0f);
		chk_irq();
		rd(OFS_MAIN);
		// event lands on the very edge of its clear: the event must survive
		fork
			bus(1'b1, OFS_DONE, 32'h000000ff);
			begin
				@(posedge clk_i);
				ev.pulse(8'h30, 8'h00);
			end
		join
		m_done = 8'h30;
		m_main[0] |= |(8'h30 & ~m_mask & DONE_VALID);
		chk_irq();
		rd(OFS_DONE);
		$display("test reset and clear race done");
		conclude();
	end
endmodule : usb_endpoint_flag_output_mask_tb
